// >>> src/malu_defs.svh
`ifndef MALU_DEFS_SVH
`define MALU_DEFS_SVH

// Opcode high nibbles of the grouped instruction families.
`define MALU_HI_INC       4'h0
`define MALU_HI_DEC       4'h1
`define MALU_HI_ADD       4'h2
`define MALU_HI_ADDC      4'h3
`define MALU_HI_ORL       4'h4
`define MALU_HI_ANL       4'h5
`define MALU_HI_XRL       4'h6
`define MALU_HI_SUBB      4'h9

// Opcode low nibbles selecting the addressing form.
`define MALU_LO_DIR_A     4'h2
`define MALU_LO_DIR_IMM   4'h3
`define MALU_LO_IMM       4'h4
`define MALU_LO_REG       4'h8

// Single opcodes.
`define MALU_OP_INC_DP    8'hA3
`define MALU_OP_MUL       8'hA4
`define MALU_OP_DIV       8'h84
`define MALU_OP_DA        8'hD4
`define MALU_OP_CLR       8'hE4
`define MALU_OP_CPL       8'hF4
`define MALU_OP_RL        8'h23
`define MALU_OP_RLC       8'h33
`define MALU_OP_RR        8'h03
`define MALU_OP_RRC       8'h13
`define MALU_OP_SWAP      8'hC4

// Cycle counts, one core clock each.
`define MALU_CYC_ONE      3'h1
`define MALU_CYC_TWO      3'h2
`define MALU_CYC_THREE    3'h3
`define MALU_CYC_FOUR     3'h4
`define MALU_CYC_MULDIV   3'h5

// Program flags word bit positions and reset values.
`define MALU_PSW_CY       7
`define MALU_PSW_AC       6
`define MALU_PSW_OV       2
`define MALU_PSW_P        0
`define MALU_PSW_RST      8'h00
`define MALU_ACC_RST      8'h00
`define MALU_B_RST        8'h00

// Decimal adjust constants.
`define MALU_BCD_MAX      4'h9
`define MALU_DA_LOW       9'h006
`define MALU_DA_HIGH      9'h060

`endif

// >>> src/malu_pkg.sv
package malu_pkg;

    typedef enum logic [0:0] {
        MALU_IDLE = 1'b0,
        MALU_BUSY = 1'b1
    } malu_state_type;

    typedef enum logic [1:0] {
        MALU_SEL_ACC = 2'b00,
        MALU_SEL_B   = 2'b01,
        MALU_SEL_PSW = 2'b10,
        MALU_SEL_NONE = 2'b11
    } malu_sfr_type;

    typedef enum logic [4:0] {
        MALU_NONE   = 5'b00000,
        MALU_ADD    = 5'b00001,
        MALU_ADDC   = 5'b00010,
        MALU_SUBB   = 5'b00011,
        MALU_INC_A  = 5'b00100,
        MALU_INC_X  = 5'b00101,
        MALU_INC_DP = 5'b00110,
        MALU_DEC_A  = 5'b00111,
        MALU_DEC_X  = 5'b01000,
        MALU_MUL    = 5'b01001,
        MALU_DIV    = 5'b01010,
        MALU_DA     = 5'b01011,
        MALU_ANL_A  = 5'b01100,
        MALU_ORL_A  = 5'b01101,
        MALU_XRL_A  = 5'b01110,
        MALU_ANL_D  = 5'b01111,
        MALU_ORL_D  = 5'b10000,
        MALU_XRL_D  = 5'b10001,
        MALU_ANL_DI = 5'b10010,
        MALU_ORL_DI = 5'b10011,
        MALU_XRL_DI = 5'b10100,
        MALU_CLR    = 5'b10101,
        MALU_CPL    = 5'b10110,
        MALU_RL     = 5'b10111,
        MALU_RLC    = 5'b11000,
        MALU_RR     = 5'b11001,
        MALU_RRC    = 5'b11010,
        MALU_SWAP   = 5'b11011
    } malu_cls_type;

    typedef struct packed {
        logic [7:0]  opcode;
        logic [7:0]  operand;
        logic [7:0]  imm;
        logic [15:0] data_pointer_reg;
    } malu_req_type;

    typedef struct packed {
        malu_cls_type cls;
        logic [2:0]   cycles;
    } malu_dec_type;

endpackage

// >>> src/malu_core.sv
`timescale 1ns/1ps
`include "malu_defs.svh"

module malu_core
    import malu_pkg::*;
(
    input  wire logic         core_clk_i,
    input  wire logic         rst_b_i,
    input  wire logic         start_i,
    input  wire malu_req_type req_i,
    input  wire logic         sfr_wr_i,
    input  wire malu_sfr_type sfr_sel_i,
    input  wire logic [7:0]   sfr_wdata_i,
    output logic [7:0]        main_operand_reg_o,
    output logic [7:0]        second_operand_reg_o,
    output logic [7:0]        program_flags_word_o,
    output logic [7:0]        result_o,
    output logic              result_valid_o,
    output logic [15:0]       data_pointer_reg_o,
    output logic              data_pointer_valid_o,
    output logic              busy_o,
    output logic              done_o,
    output logic              unknown_op_o
);

    function automatic malu_dec_type decode(input logic [7:0] opc);
        malu_dec_type d;
        logic [3:0]   hi;
        logic [3:0]   lo;
        hi       = opc[7:4];
        lo       = opc[3:0];
        d.cls    = MALU_NONE;
        d.cycles = `MALU_CYC_ONE;
        case (opc)
            `MALU_OP_INC_DP: d.cls = MALU_INC_DP;
            `MALU_OP_MUL: begin
                d.cls    = MALU_MUL;
                d.cycles = `MALU_CYC_MULDIV;
            end
            `MALU_OP_DIV: begin
                d.cls    = MALU_DIV;
                d.cycles = `MALU_CYC_MULDIV;
            end
            `MALU_OP_DA:   d.cls = MALU_DA;
            `MALU_OP_CLR:  d.cls = MALU_CLR;
            `MALU_OP_CPL:  d.cls = MALU_CPL;
            `MALU_OP_RL:   d.cls = MALU_RL;
            `MALU_OP_RLC:  d.cls = MALU_RLC;
            `MALU_OP_RR:   d.cls = MALU_RR;
            `MALU_OP_RRC:  d.cls = MALU_RRC;
            `MALU_OP_SWAP: d.cls = MALU_SWAP;
            default: begin
                if (lo >= `MALU_LO_IMM) begin
                    // Immediate, direct, indirect and register forms.
                    case (hi)
                        `MALU_HI_ADD:  d.cls = MALU_ADD;
                        `MALU_HI_ADDC: d.cls = MALU_ADDC;
                        `MALU_HI_SUBB: d.cls = MALU_SUBB;
                        `MALU_HI_ANL:  d.cls = MALU_ANL_A;
                        `MALU_HI_ORL:  d.cls = MALU_ORL_A;
                        `MALU_HI_XRL:  d.cls = MALU_XRL_A;
                        `MALU_HI_INC: begin
                            d.cls = (lo == `MALU_LO_IMM) ? MALU_INC_A
                                                         : MALU_INC_X;
                        end
                        `MALU_HI_DEC: begin
                            d.cls = (lo == `MALU_LO_IMM) ? MALU_DEC_A
                                                         : MALU_DEC_X;
                        end
                        default: d.cls = MALU_NONE;
                    endcase
                    if (hi == `MALU_HI_INC || hi == `MALU_HI_DEC) begin
                        if (lo == `MALU_LO_IMM) begin
                            d.cycles = `MALU_CYC_ONE;
                        end else if (lo >= `MALU_LO_REG) begin
                            d.cycles = `MALU_CYC_TWO;
                        end else begin
                            d.cycles = `MALU_CYC_THREE;
                        end
                    end else if (lo >= `MALU_LO_REG) begin
                        d.cycles = `MALU_CYC_ONE;
                    end else begin
                        d.cycles = `MALU_CYC_TWO;
                    end
                end else if (lo == `MALU_LO_DIR_A) begin
                    d.cycles = `MALU_CYC_THREE;
                    case (hi)
                        `MALU_HI_ANL: d.cls = MALU_ANL_D;
                        `MALU_HI_ORL: d.cls = MALU_ORL_D;
                        `MALU_HI_XRL: d.cls = MALU_XRL_D;
                        default: begin
                            d.cls    = MALU_NONE;
                            d.cycles = `MALU_CYC_ONE;
                        end
                    endcase
                end else if (lo == `MALU_LO_DIR_IMM) begin
                    d.cycles = `MALU_CYC_FOUR;
                    case (hi)
                        `MALU_HI_ANL: d.cls = MALU_ANL_DI;
                        `MALU_HI_ORL: d.cls = MALU_ORL_DI;
                        `MALU_HI_XRL: d.cls = MALU_XRL_DI;
                        default: begin
                            d.cls    = MALU_NONE;
                            d.cycles = `MALU_CYC_ONE;
                        end
                    endcase
                end
            end
        endcase
        return d;
    endfunction

    malu_state_type state;
    malu_state_type next_state;
    malu_req_type   cur;
    malu_req_type   next_cur;
    logic [2:0]     cnt;
    logic [2:0]     next_cnt;
    logic           busy;
    logic           next_busy;
    logic           commit;
    malu_req_type   sel;
    malu_dec_type   dec;

    logic [7:0]     acc;
    logic [7:0]     next_acc;
    logic [7:0]     breg;
    logic [7:0]     next_breg;
    logic [7:0]     program_flags_word;
    logic [7:0]     next_psw;
    logic [7:0]     result;
    logic [7:0]     next_result;
    logic           rvalid;
    logic           next_rvalid;
    logic [15:0]    data_pointer_reg;
    logic [15:0]    next_data_pointer_reg;
    logic           dvalid;
    logic           next_dvalid;
    logic           done;
    logic           next_done;
    logic           unknown;
    logic           next_unknown;

    // A request in flight is held in cur, so the decoder keeps its
    // opcode even after the control unit has moved its inputs on.
    assign sel = (state == MALU_IDLE) ? req_i : cur;
    assign dec = decode(sel.opcode);

    always_comb begin
        next_state = state;
        next_cur   = cur;
        next_cnt   = cnt;
        commit     = 1'b0;
        case (state)
            MALU_IDLE: begin
                if (start_i) begin
                    next_cur = req_i;
                    if (dec.cycles == `MALU_CYC_ONE) begin
                        commit = 1'b1;
                    end else begin
                        next_state = MALU_BUSY;
                        next_cnt   = dec.cycles - `MALU_CYC_ONE;
                    end
                end
            end
            MALU_BUSY: begin
                next_cnt = cnt - `MALU_CYC_ONE;
                if (cnt == `MALU_CYC_ONE) begin
                    commit     = 1'b1;
                    next_state = MALU_IDLE;
                end
            end
            default: next_state = MALU_IDLE;
        endcase
        next_busy = (next_state == MALU_BUSY);
    end

    always_ff @(posedge core_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            state <= MALU_IDLE;
            cur   <= '0;
            cnt   <= 3'h0;
            busy  <= 1'b0;
        end else begin
            state <= next_state;
            cur   <= next_cur;
            cnt   <= next_cnt;
            busy  <= next_busy;
        end
    end

    always_comb begin
        logic [7:0]  a;
        logic [7:0]  op;
        logic        cin;
        logic [8:0]  sum;
        logic [4:0]  nib;
        logic [15:0] prod;
        logic [8:0]  t;
        logic        c;
        a            = acc;
        op           = sel.operand;
        cin          = 1'b0;
        sum          = 9'h000;
        nib          = 5'h00;
        prod         = 16'h0000;
        t            = 9'h000;
        c            = 1'b0;
        next_acc     = acc;
        next_breg    = breg;
        next_psw     = program_flags_word;
        next_result  = result;
        next_rvalid  = 1'b0;
        next_data_pointer_reg    = data_pointer_reg;
        next_dvalid  = 1'b0;
        next_done    = commit;
        next_unknown = 1'b0;
        // Control unit writes land first; a committing operation overrides
        // the registers and flag bits it writes in the same cycle.
        if (sfr_wr_i) begin
            case (sfr_sel_i)
                MALU_SEL_ACC: next_acc  = sfr_wdata_i;
                MALU_SEL_B:   next_breg = sfr_wdata_i;
                MALU_SEL_PSW: next_psw  = sfr_wdata_i;
                default:      next_acc  = acc;
            endcase
        end
        if (commit) begin
            case (dec.cls)
                MALU_ADD, MALU_ADDC: begin
                    cin = (dec.cls == MALU_ADDC) ? program_flags_word[`MALU_PSW_CY] : 1'b0;
                    sum = {1'b0, a} + {1'b0, op} + {8'h00, cin};
                    nib = {1'b0, a[3:0]} + {1'b0, op[3:0]} + {4'h0, cin};
                    next_acc               = sum[7:0];
                    next_psw[`MALU_PSW_CY] = sum[8];
                    next_psw[`MALU_PSW_AC] = nib[4];
                    next_psw[`MALU_PSW_OV] = (a[7] == op[7]) &&
                                             (sum[7] != a[7]);
                end
                MALU_SUBB: begin
                    cin = program_flags_word[`MALU_PSW_CY];
                    sum = {1'b0, a} - {1'b0, op} - {8'h00, cin};
                    nib = {1'b0, a[3:0]} - {1'b0, op[3:0]} - {4'h0, cin};
                    next_acc               = sum[7:0];
                    next_psw[`MALU_PSW_CY] = sum[8];
                    next_psw[`MALU_PSW_AC] = nib[4];
                    next_psw[`MALU_PSW_OV] = (a[7] != op[7]) &&
                                             (sum[7] != a[7]);
                end
                MALU_INC_A: next_acc = a + 8'h01;
                MALU_DEC_A: next_acc = a - 8'h01;
                MALU_INC_X: begin
                    next_result = op + 8'h01;
                    next_rvalid = 1'b1;
                end
                MALU_DEC_X: begin
                    next_result = op - 8'h01;
                    next_rvalid = 1'b1;
                end
                MALU_INC_DP: begin
                    next_data_pointer_reg   = sel.data_pointer_reg + 16'h0001;
                    next_dvalid = 1'b1;
                end
                MALU_MUL: begin
                    prod                   = a * breg;
                    next_acc               = prod[7:0];
                    next_breg              = prod[15:8];
                    next_psw[`MALU_PSW_CY] = 1'b0;
                    next_psw[`MALU_PSW_OV] = (prod[15:8] != 8'h00);
                end
                MALU_DIV: begin
                    next_psw[`MALU_PSW_CY] = 1'b0;
                    // A zero divisor leaves both registers untouched and
                    // raises overflow, so software can detect it.
                    if (breg == 8'h00) begin
                        next_psw[`MALU_PSW_OV] = 1'b1;
                    end else begin
                        next_acc               = a / breg;
                        next_breg              = a % breg;
                        next_psw[`MALU_PSW_OV] = 1'b0;
                    end
                end
                MALU_DA: begin
                    t = {1'b0, a};
                    c = program_flags_word[`MALU_PSW_CY];
                    if (t[3:0] > `MALU_BCD_MAX || program_flags_word[`MALU_PSW_AC]) begin
                        t = t + `MALU_DA_LOW;
                        c = c | t[8];
                    end
                    if (t[7:4] > `MALU_BCD_MAX || c) begin
                        t = {1'b0, t[7:0]} + `MALU_DA_HIGH;
                        c = c | t[8];
                    end
                    next_acc               = t[7:0];
                    next_psw[`MALU_PSW_CY] = c;
                end
                MALU_ANL_A: next_acc = a & op;
                MALU_ORL_A: next_acc = a | op;
                MALU_XRL_A: next_acc = a ^ op;
                MALU_ANL_D, MALU_ORL_D, MALU_XRL_D: begin
                    next_rvalid = 1'b1;
                    if (dec.cls == MALU_ANL_D) begin
                        next_result = op & a;
                    end else if (dec.cls == MALU_ORL_D) begin
                        next_result = op | a;
                    end else begin
                        next_result = op ^ a;
                    end
                end
                MALU_ANL_DI, MALU_ORL_DI, MALU_XRL_DI: begin
                    next_rvalid = 1'b1;
                    if (dec.cls == MALU_ANL_DI) begin
                        next_result = op & sel.imm;
                    end else if (dec.cls == MALU_ORL_DI) begin
                        next_result = op | sel.imm;
                    end else begin
                        next_result = op ^ sel.imm;
                    end
                end
                MALU_CLR:  next_acc = 8'h00;
                MALU_CPL:  next_acc = ~a;
                MALU_RL:   next_acc = {a[6:0], a[7]};
                MALU_RR:   next_acc = {a[0], a[7:1]};
                MALU_RLC: begin
                    next_acc               = {a[6:0], program_flags_word[`MALU_PSW_CY]};
                    next_psw[`MALU_PSW_CY] = a[7];
                end
                MALU_RRC: begin
                    next_acc               = {program_flags_word[`MALU_PSW_CY], a[7:1]};
                    next_psw[`MALU_PSW_CY] = a[0];
                end
                MALU_SWAP: next_acc = {a[3:0], a[7:4]};
                default:   next_unknown = 1'b1;
            endcase
        end
        // Parity is derived, so a direct write to the flags word cannot
        // leave it out of step with the main operand register.
        next_psw[`MALU_PSW_P] = ^next_acc;
    end

    always_ff @(posedge core_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            acc     <= `MALU_ACC_RST;
            breg    <= `MALU_B_RST;
            program_flags_word     <= `MALU_PSW_RST;
            result  <= 8'h00;
            rvalid  <= 1'b0;
            data_pointer_reg    <= 16'h0000;
            dvalid  <= 1'b0;
            done    <= 1'b0;
            unknown <= 1'b0;
        end else begin
            acc     <= next_acc;
            breg    <= next_breg;
            program_flags_word     <= next_psw;
            result  <= next_result;
            rvalid  <= next_rvalid;
            data_pointer_reg    <= next_data_pointer_reg;
            dvalid  <= next_dvalid;
            done    <= next_done;
            unknown <= next_unknown;
        end
    end

    assign main_operand_reg_o   = acc;
    assign second_operand_reg_o = breg;
    assign program_flags_word_o = program_flags_word;
    assign result_o             = result;
    assign result_valid_o       = rvalid;
    assign data_pointer_reg_o   = data_pointer_reg;
    assign data_pointer_valid_o = dvalid;
    assign busy_o               = busy;
    assign done_o               = done;
    assign unknown_op_o         = unknown;

endmodule

// >>> tb/malu_ctl_model.sv
`timescale 1ns/1ps
module malu_ctl_model
    import malu_pkg::*;
(
    input  wire logic    core_clk_i,
    input  wire logic    done_i,
    input  wire logic    unknown_i,
    input  wire logic [7:0] result_i,
    output malu_req_type req_o,
    output logic         start_o,
    output logic         sfr_wr_o,
    output malu_sfr_type sfr_sel_o,
    output logic [7:0]   sfr_wdata_o
);
    initial begin
        start_o = 1'b0;
        req_o = '0;
        sfr_wr_o = 1'b0;
        sfr_sel_o = MALU_SEL_NONE;
        sfr_wdata_o = 8'h00;
    end
    // Request lines are scrambled once taken, so a late sample shows.
    task automatic issue(input logic [7:0] op, input logic [7:0] opnd,
                         input logic [7:0] imm, input logic [15:0] dp,
                         output int n, output logic [7:0] res,
                         output logic unk);
        @(negedge core_clk_i);
        start_o = 1'b1;
        req_o = '{op, opnd, imm, dp};
        n = 0;
        do begin
            @(negedge core_clk_i);
            start_o = 1'b0;
            req_o = ~req_o;
            n++;
        end while (done_i !== 1'b1 && n < 20);
        res = result_i;
        unk = unknown_i;
    endtask
    task automatic wr(input malu_sfr_type sel, input logic [7:0] d);
        @(negedge core_clk_i);
        sfr_wr_o = 1'b1;
        sfr_sel_o = sel;
        sfr_wdata_o = d;
        @(negedge core_clk_i);
        sfr_wr_o = 1'b0;
        sfr_wdata_o = ~d;
    endtask
endmodule

// >>> tb/malu_core_assertions.sv
`timescale 1ns/1ps
module malu_core_chk
    import malu_pkg::*;
(
    input wire logic         core_clk_i,
    input wire logic         rst_b_i,
    input wire logic         start_i,
    input wire malu_req_type req_i,
    input wire logic [7:0]   main_operand_reg_o,
    input wire logic [7:0]   program_flags_word_o,
    input wire logic         result_valid_o,
    input wire logic [15:0]  data_pointer_reg_o,
    input wire logic         data_pointer_valid_o,
    input wire logic         busy_o,
    input wire logic         done_o,
    input wire logic         unknown_op_o
);
    default clocking cb @(posedge core_clk_i);
    endclocking
    default disable iff (!rst_b_i);
    logic       take;
    logic [7:0] op;
    logic [7:0] acc;
    assign take = start_i && !busy_o;
    assign op = req_i.opcode;
    assign acc = main_operand_reg_o;
    sequence s_fin;
        done_o && !busy_o;
    endsequence
    sequence s_wait4;
        (busy_o && !done_o) [*4];
    endsequence
    property p_add_reg;
        take && op inside {[8'h28:8'h2f]} |=> s_fin;
    endproperty
    a_add_reg: assert property (p_add_reg) else $error("add reg late");
    property p_add_dir;
        take && op == 8'h25 |=> busy_o ##1 s_fin;
    endproperty
    a_add_dir: assert property (p_add_dir) else $error("add dir late");
    property p_muldiv;
        take && op inside {8'ha4, 8'h84} |=> s_wait4 ##1 s_fin;
    endproperty
    a_muldiv: assert property (p_muldiv) else $error("muldiv timing");
    property p_inc_dir;
        take && op == 8'h05 |=> !done_o [*2] ##1 done_o && result_valid_o;
    endproperty
    a_inc_dir: assert property (p_inc_dir) else $error("inc dir");
    property p_orl_di;
        take && op == 8'h43 |=> !done_o [*3] ##1 s_fin;
    endproperty
    a_orl_di: assert property (p_orl_di) else $error("orl imm late");
    property p_parity;
        program_flags_word_o[0] == ^acc;
    endproperty
    a_parity: assert property (p_parity) else $error("parity");
    property p_clr;
        take && op == 8'he4 |=> acc == 8'h00;
    endproperty
    a_clr: assert property (p_clr) else $error("clear");
    property p_swap;
        take && op == 8'hc4 |=> acc == {$past(acc[3:0]), $past(acc[7:4])};
    endproperty
    a_swap: assert property (p_swap) else $error("swap");
    property p_unk;
        unknown_op_o |-> done_o;
    endproperty
    a_unk: assert property (p_unk) else $error("unknown without done");
    property p_dp;
        take && op == 8'ha3 |=> data_pointer_valid_o
            && data_pointer_reg_o == $past(req_i.data_pointer_reg) + 16'h0001;
    endproperty
    a_dp: assert property (p_dp) else $error("pointer step");
endmodule
bind malu_core malu_core_chk chk_u (
    .core_clk_i(core_clk_i), .rst_b_i(rst_b_i), .start_i(start_i),
    .req_i(req_i), .main_operand_reg_o(main_operand_reg_o),
    .program_flags_word_o(program_flags_word_o),
    .result_valid_o(result_valid_o), .data_pointer_reg_o(data_pointer_reg_o),
    .data_pointer_valid_o(data_pointer_valid_o), .busy_o(busy_o),
    .done_o(done_o), .unknown_op_o(unknown_op_o)
);

// >>> tb/tb_top.sv
`timescale 1ns/1ps
module tb_top;
    import malu_pkg::*;
    logic         core_clk_i = 1'b0;
    logic         rst_b_i = 1'b0;
    malu_req_type req;
    malu_sfr_type sel;
    logic         start, sfr_wr, rv, dpv, busy, done, unk, got_unk;
    logic [7:0]   wdata, acc, sec, flg, res, got_res;
    logic [15:0]  dp;
    int           got_n;
    int           error_cnt = 0;
    int           cmp_count = 0;

    always #20 core_clk_i = ~core_clk_i;

    malu_core dut_u (
        .core_clk_i(core_clk_i), .rst_b_i(rst_b_i), .start_i(start),
        .req_i(req), .sfr_wr_i(sfr_wr), .sfr_sel_i(sel), .sfr_wdata_i(wdata),
        .main_operand_reg_o(acc), .second_operand_reg_o(sec),
        .program_flags_word_o(flg), .result_o(res), .result_valid_o(rv),
        .data_pointer_reg_o(dp), .data_pointer_valid_o(dpv), .busy_o(busy),
        .done_o(done), .unknown_op_o(unk)
    );
    malu_ctl_model ctl_u (
        .core_clk_i(core_clk_i), .done_i(done), .unknown_i(unk),
        .result_i(res), .req_o(req), .start_o(start), .sfr_wr_o(sfr_wr),
        .sfr_sel_o(sel), .sfr_wdata_o(wdata)
    );

    task automatic chk(input string what, input logic [15:0] exp,
                       input logic [15:0] got);
        cmp_count++;
        if (got !== exp) begin
            error_cnt++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic wrap_up();
        if (error_cnt == 0 && cmp_count > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    task automatic run(input logic [7:0] op, input logic [7:0] opnd,
                       input logic [7:0] imm, input int cyc);
        ctl_u.issue(op, opnd, imm, 16'h12ff, got_n, got_res, got_unk);
        chk("cycles", cyc[15:0], got_n[15:0]);
    endtask
    task automatic t_arith();
        chk("reset", 16'h0000, {acc, flg});
        ctl_u.wr(MALU_SEL_ACC, 8'hf0);
        run(8'h28, 8'h20, 8'h00, 1);
        chk("add", {8'h10, 8'h81}, {acc, flg});
        run(8'h34, 8'h01, 8'h00, 2);
        chk("addc", 8'h12, acc);
        run(8'h94, 8'h13, 8'h00, 2);
        chk("subb", {8'hff, 8'hc0}, {acc, flg});
        ctl_u.wr(MALU_SEL_ACC, 8'h40);
        ctl_u.wr(MALU_SEL_B, 8'h08);
        run(8'ha4, 8'h00, 8'h00, 5);
        chk("mul", {8'h00, 8'h02}, {acc, sec});
        chk("mul flags", 8'h44, flg);
        ctl_u.wr(MALU_SEL_ACC, 8'h64);
        ctl_u.wr(MALU_SEL_B, 8'h07);
        run(8'h84, 8'h00, 8'h00, 5);
        chk("div", {8'h0e, 8'h02}, {acc, sec});
        ctl_u.wr(MALU_SEL_B, 8'h00);
        run(8'h84, 8'h00, 8'h00, 5);
        chk("div zero", {8'h0e, 8'h00}, {acc, sec});
        chk("div zero flags", 8'h45, flg);
    endtask
    // Each step starts from the previous result, so one slip shows onward.
    task automatic t_logic();
        logic [111:0] ops = 112'h5848_68f4_2303_c433_1304_14e4_4465;
        logic [111:0] opd = 112'h0f30_ff00_0000_0000_0000_0000_8181;
        logic [111:0] exp = 112'h0535_ca35_6a35_53a6_5354_5300_8100;
        ctl_u.wr(MALU_SEL_ACC, 8'ha5);
        for (int i = 13; i >= 0; i--) begin
            run(ops[8*i+:8], opd[8*i+:8], 8'h00, (i < 2) ? 2 : 1);
            chk("acc", exp[8*i+:8], acc);
        end
    endtask
    task automatic t_ext();
        run(8'h05, 8'h7f, 8'h00, 3);
        chk("inc dir", 8'h80, got_res);
        run(8'h15, 8'h00, 8'h00, 3);
        chk("dec dir", 8'hff, got_res);
        run(8'h43, 8'h0c, 8'h30, 4);
        chk("orl dir imm", 8'h3c, got_res);
        run(8'h62, 8'h5a, 8'h00, 3);
        chk("xrl dir", 8'h5a, got_res);
        run(8'h53, 8'hff, 8'h0f, 4);
        chk("anl dir imm", 8'h0f, got_res);
        run(8'h18, 8'h00, 8'h00, 2);
        chk("dec reg", 8'hff, got_res);
        run(8'ha3, 8'h00, 8'h00, 1);
        chk("data_pointer_reg", 16'h1300, dp);
        ctl_u.issue(8'h80, 8'h00, 8'h00, 16'h0000, got_n, got_res, got_unk);
        chk("unknown", 1'b1, got_unk);
        chk("acc kept", 8'h00, acc);
        ctl_u.wr(MALU_SEL_PSW, 8'h00);
        ctl_u.wr(MALU_SEL_ACC, 8'h9a);
        run(8'hd4, 8'h00, 8'h00, 1);
        chk("da", {8'h00, 8'h80}, {acc, flg});
    endtask

    initial begin
        repeat (3) @(negedge core_clk_i);
        rst_b_i = 1'b1;
        t_arith();
        t_logic();
        t_ext();
        wrap_up();
    end
    initial begin
        #(40 * 3000);
        error_cnt++;
        wrap_up();
    end
endmodule
